/* core/led_fault_supervisor.sv */
// Fault supervisor and recovery controller for a boost LED driver.
// Assumes comparator flags and host pins are asynchronous; all are synchronised here.
`timescale 1ns/10ps
module led_fault_supervisor #(
  parameter int unsigned CLEAR_COUNT   = fault_sup_pkg::CLEAR_CYCLES,
  parameter int unsigned LOCKOUT_COUNT = fault_sup_pkg::LOCKOUT_CYCLES,
  parameter int unsigned NSTR          = fault_sup_pkg::NUM_STRINGS
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        enable_in,
  input  wire logic                        dimming_in,
  input  wire logic                        low_freq_variant,
  input  wire logic                        switching_clock,
  input  wire fault_sup_pkg::fault_flags_t fault_flags,
  input  wire fault_sup_pkg::string_flags_t string_flags,
  output logic                             boost_switch_enable,
  output logic                             on_time_truncate,
  output logic                             disconnect_on,
  output logic [NSTR-1:0]                  sink_enable,
  output logic                             fault_n,
  output logic                             switching_clock_output,
  output logic                             latched
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int unsigned SW = 8 + 3 * NSTR + 3;

  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync_in;

  assign raw_in = {fault_flags, string_flags, enable_in, dimming_in, low_freq_variant};

  sync2 #(
    .W        (SW)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  fault_sup_pkg::fault_flags_t  ff_s;
  fault_sup_pkg::string_flags_t sf_s;
  logic                         en_s;
  logic                         dim_s;
  logic                         lf_s;

  assign ff_s  = fault_sup_pkg::fault_flags_t'(sync_in[SW-1 -: 8]);
  assign sf_s  = fault_sup_pkg::string_flags_t'(sync_in[SW-9 -: 3*NSTR]);
  assign en_s  = sync_in[2];
  assign dim_s = sync_in[1];
  assign lf_s  = sync_in[0];

  // ----------------------------------------------------------------
  // Supply lockout filter
  // ----------------------------------------------------------------
  logic [15:0] lock_cnt_q;
  logic [15:0] lock_cnt_d;
  logic        lockout_q;
  logic        lockout_d;

  always_comb begin
    lock_cnt_d = lock_cnt_q;
    lockout_d  = lockout_q;
    if (!ff_s.supply_low) begin
      lock_cnt_d = 16'h0000;
      lockout_d  = 1'b0;
    end else if (lock_cnt_q >= 16'(LOCKOUT_COUNT)) begin
      lockout_d = 1'b1; // see R19
    end else begin
      lock_cnt_d = lock_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_cnt_q <= 16'h0000;
      lockout_q  <= 1'b0;
    end else begin
      lock_cnt_q <= lock_cnt_d;
      lockout_q  <= lockout_d;
    end
  end

  // ----------------------------------------------------------------
  // Latch clearing counter
  // ----------------------------------------------------------------
  // Counts an uninterrupted low of enable, or of dimming while enable is high.
  logic [16:0] clr_cnt_q;
  logic [16:0] clr_cnt_d;
  logic        clr_done;
  logic [16:0] clr_limit;
  logic        low_seen;
  fault_sup_pkg::sup_state_t state_q;
  fault_sup_pkg::sup_state_t state_d;

  assign clr_limit = lf_s ? 17'(fault_sup_pkg::CLEAR_CYCLES_LF) : 17'(CLEAR_COUNT);
  assign low_seen  = !en_s || !dim_s; // see R9, R10
  assign clr_done  = (clr_cnt_q > clr_limit);

  always_comb begin
    clr_cnt_d = clr_cnt_q;
    if (!low_seen || state_q != fault_sup_pkg::ST_LATCHED) begin
      clr_cnt_d = 17'h00000; // see R21
    end else if (!clr_done) begin
      clr_cnt_d = clr_cnt_q + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Supervisor state
  // ----------------------------------------------------------------
  logic                      dim_prev_q;
  logic                      dim_rise;
  logic                      latch_event;
  logic [NSTR-1:0]           short_off_q;
  logic [NSTR-1:0]           short_off_d;
  logic                      any_low_pin;

  assign dim_rise    = dim_s && !dim_prev_q;
  // Checked in every state, so a latching event is never missed mid-transition
  assign latch_event = ff_s.input_overcurrent || ff_s.switch_overcurrent2
                     || ff_s.switch_overvoltage2; // see R8, R17, R18
  assign any_low_pin = |sf_s.below_1v2;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fault_sup_pkg::ST_IDLE: begin
        if (en_s && dim_s) begin
          state_d = fault_sup_pkg::ST_RUN;
        end
      end
      fault_sup_pkg::ST_RUN: begin
        if (!en_s) begin
          state_d = fault_sup_pkg::ST_IDLE;
        end
      end
      fault_sup_pkg::ST_LATCHED: begin
        if (clr_done) begin
          state_d = fault_sup_pkg::ST_CLEARED; // see R14, R15
        end
      end
      fault_sup_pkg::ST_CLEARED: begin
        if (dim_rise && en_s) begin
          state_d = fault_sup_pkg::ST_RUN; // see R16
        end
      end
      default: begin
        state_d = fault_sup_pkg::ST_IDLE;
      end
    endcase
    // A completed clear always shows one released cycle before a relatch
    if (latch_event && !(state_q == fault_sup_pkg::ST_LATCHED && clr_done)) begin
      state_d = fault_sup_pkg::ST_LATCHED; // see R12, R14
    end
    if (lockout_q) begin
      state_d = fault_sup_pkg::ST_IDLE; // see R6
    end
  end

  // Partial-short string removal per string
  always_comb begin
    short_off_d = short_off_q;
    for (int i = 0; i < NSTR; i++) begin
      if (dim_rise || !sf_s.above_short_threshold[i]) begin
        short_off_d[i] = 1'b0; // see R4
      end else if (sf_s.in_regulation[i] && (|(sf_s.below_1v2 & ~(NSTR'(1) << i)))) begin
        short_off_d[i] = 1'b1; // see R3
      end
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  logic            run;
  logic            sw_d;
  logic            disc_d;
  logic [NSTR-1:0] sink_d;
  logic            fault_n_d;

  assign run = (state_q == fault_sup_pkg::ST_RUN);

  always_comb begin
    sw_d      = run;
    disc_d    = run;
    sink_d    = run ? ~short_off_q : '0;
    fault_n_d = 1'b1;
    if (ff_s.overvoltage_sense) begin
      sw_d = 1'b0; // see R1, R7
    end
    if (ff_s.output_undervoltage) begin
      sw_d      = 1'b0; // see R2
      sink_d    = '0;
      fault_n_d = 1'b0;
    end
    if (ff_s.over_temperature) begin
      sw_d      = 1'b0; // see R5
      disc_d    = 1'b0;
      sink_d    = '0;
      fault_n_d = 1'b0;
    end
    if (state_d == fault_sup_pkg::ST_LATCHED) begin
      sw_d      = 1'b0; // see R13
      disc_d    = 1'b0;
      sink_d    = '0;
      fault_n_d = 1'b0;
    end
    if (lockout_q) begin
      sw_d      = 1'b0;
      disc_d    = 1'b0;
      sink_d    = '0;
      fault_n_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q                <= fault_sup_pkg::ST_IDLE;
      dim_prev_q             <= 1'b0;
      short_off_q            <= '0;
      clr_cnt_q              <= 17'h00000;
      boost_switch_enable    <= fault_sup_pkg::RST_SWITCH;
      disconnect_on          <= fault_sup_pkg::RST_DISCON;
      sink_enable            <= '0;
      fault_n                <= fault_sup_pkg::RST_FAULT_N;
      on_time_truncate       <= 1'b0;
      latched                <= 1'b0;
      switching_clock_output <= 1'b0;
    end else begin
      state_q                <= state_d;
      dim_prev_q             <= dim_s;
      short_off_q            <= short_off_d;
      clr_cnt_q              <= clr_cnt_d;
      boost_switch_enable    <= sw_d;
      disconnect_on          <= disc_d;
      sink_enable            <= sink_d;
      fault_n                <= fault_n_d;
      // Cycle-by-cycle limit: no state change, no fault pin
      on_time_truncate       <= ff_s.primary_current_limit; // see R20
      latched                <= (state_d == fault_sup_pkg::ST_LATCHED);
      // Clock output never gated by faults or latch clearing
      switching_clock_output <= switching_clock; // see R11
    end
  end

endmodule : led_fault_supervisor

/* core/fault_sup_pkg.sv */
// Constants and carrier types for the LED driver fault supervisor.
// Assumes a single 40 MHz clock and comparator flags that arrive from analog logic.
//
// What this block does
// R1: Over-voltage halts switching, sinks stay on, resume at ~94% level, no fault pin.
// R2: Under-voltage stops switching and sinks, disconnect on, fault pin low, auto-restart.
// R3: Disable string over short threshold while regulating and another sink below 1.2 V.
// R4: Re-enable shorted string when pin drops below threshold or at dimming rise.
// R5: Over-temperature turns everything off, fault pin low, restart after hysteresis.
// R6: Supply lockout turns everything off and clears latches, fault pin stays high.
// R7: All non-latching faults resume automatically once the condition is gone.
// R8: Only input overcurrent, switch secondary overcurrent and secondary over-voltage latch.
// R9: Enable held low over 32k cycles clears a latched fault; with low_freq_variant set the block clears after 8k.
// R10: Enable high with dimming low over 32k (8k variant) cycles clears latch.
// R11: Clearing by dimming low keeps the clock output toggling.
// R12: A fault still present after clearing is caught again and relatches.
// R13: Latched state drives fault pin low and keeps clock output running.
// R14: Completed clearing count releases the latch and returns fault pin high.
// R15: While latched the device does not start even with dimming high.
// R16: After clearing, restart happens at the next rising of the dimming input.
// R17: Fault detection runs in every state and every transition.
// R18: Switch secondary overcurrent turns everything off, fault pin low, latches.
// R19: Supply lockout counts only after the low indication persists over 50 us.
// R20: Primary current limit ends the on-time at once, no fault pin.
// R21: Clearing counter restarts whenever the monitored input goes high early.
package fault_sup_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned LOCKOUT_FILTER_US = 50;
  localparam int unsigned LOCKOUT_CYCLES    = (LOCKOUT_FILTER_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CLEAR_CYCLES      = 32768;
  localparam int unsigned CLEAR_CYCLES_LF   = 8192;
  localparam int unsigned CNT_W             = 16;
  localparam int unsigned NUM_STRINGS       = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_FAULT_N  = 1'b1;
  localparam logic RST_SWITCH   = 1'b0;
  localparam logic RST_DISCON   = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RUN     = 2'b01,
    ST_LATCHED = 2'b11,
    ST_CLEARED = 2'b10
  } sup_state_t;

  typedef struct packed {
    logic overvoltage_sense;
    logic output_undervoltage;
    logic over_temperature;
    logic supply_low;
    logic input_overcurrent;
    logic switch_overcurrent2;
    logic switch_overvoltage2;
    logic primary_current_limit;
  } fault_flags_t;

  typedef struct packed {
    logic [NUM_STRINGS-1:0] above_short_threshold;
    logic [NUM_STRINGS-1:0] in_regulation;
    logic [NUM_STRINGS-1:0] below_1v2;
  } string_flags_t;

endpackage : fault_sup_pkg

/* core/sync2.sv */
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs are quasi-static relative to sys_clk.
`timescale 1ns/10ps
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync2

/* tb/fault_sup_asserts.sv */
// Port checker for led_fault_supervisor.
// Bound from tb; inputs are the top module's ports.
`timescale 1ns/10ps
module fault_sup_asserts #(
  parameter int unsigned CLEAR_COUNT   = fault_sup_pkg::CLEAR_CYCLES,
  parameter int unsigned LOCKOUT_COUNT = fault_sup_pkg::LOCKOUT_CYCLES
) (
  input wire logic                        sys_clk,
  input wire logic                        reset_n,
  input wire logic                        enable_in,
  input wire logic                        dimming_in,
  input wire logic                        switching_clock,
  input wire fault_sup_pkg::fault_flags_t fault_flags,
  input wire logic                        boost_switch_enable,
  input wire logic                        on_time_truncate,
  input wire logic                        disconnect_on,
  input wire logic [3:0]                  sink_enable,
  input wire logic                        fault_n,
  input wire logic                        switching_clock_output,
  input wire logic                        latched
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic        src, sl, off;
  logic [15:0] low_q, low_d, sl_q, sl_d;
  assign src = fault_flags[3] | fault_flags[2] | fault_flags[1];
  assign sl  = fault_flags.supply_low;
  assign off = !boost_switch_enable && sink_enable == 4'h0;
  // ----------------------------------------------------------------
  // Run-length counters of low host inputs and of supply low
  // ----------------------------------------------------------------
  always_comb begin
    low_d = (enable_in && dimming_in) ? 16'h0000 : low_q + 16'h0001;
    sl_d  = sl ? sl_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 16'h0000;
      sl_q  <= 16'h0000;
    end else begin
      low_q <= low_d;
      sl_q  <= sl_d;
    end
  end
  sequence s_uv; (fault_flags.output_undervoltage && !sl)[*6]; endsequence
  sequence s_ot; (fault_flags.over_temperature && !sl)[*6]; endsequence
  AST_UV_OFF: assert property (s_uv |-> off && !fault_n)
    else $error("undervoltage response wrong");
  AST_OT_OFF: assert property (s_ot |-> off && !disconnect_on && !fault_n)
    else $error("overtemperature response wrong");
  AST_OV_HALT: assert property (fault_flags.overvoltage_sense[*4] |-> !boost_switch_enable)
    else $error("switching not halted");
  AST_TRUNC: assert property (fault_flags.primary_current_limit[*4] |-> on_time_truncate)
    else $error("on-time not truncated");
  AST_LATCH_OFF: assert property (latched |-> off && !disconnect_on && !fault_n)
    else $error("latched outputs wrong");
  AST_LATCH_IN: assert property ((src && !sl)[*4] |-> ##[0:4] latched)
    else $error("latching fault not latched");
  AST_LATCH_WHY: assert property ($rose(latched) |-> $past(src, 3) || $past(src, 4))
    else $error("latch without latching cause");
  // Lockout clears too, so only releases outside lockout are judged
  AST_CLEAR_LONG: assert property ($fell(latched) && sl_q == 16'h0000 |-> low_q > CLEAR_COUNT)
    else $error("latch released early");
  AST_LOCKOUT: assert property (sl_q > LOCKOUT_COUNT + 4 |-> off && fault_n && !latched)
    else $error("lockout response wrong");
  AST_SWITCHING_CLOCK_OUTPUT: assert property ($changed(switching_clock) |-> ##[1:4] $changed(switching_clock_output))
    else $error("clock output stalled");
endmodule : fault_sup_asserts

/* tb/host_model.sv */
// Host model driving the enable and dimming lines.
// Assumes tb calls its tasks; lines change just after rising edges.
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk,
  output logic     enable_in,
  output logic     dimming_in
);
  initial begin
    enable_in = 1'b0;
    dimming_in = 1'b0;
  end
  task automatic drive(input logic en, input logic dim, input int n);
    @(posedge sys_clk);
    enable_in <= en;
    dimming_in <= dim;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : drive
  // Margin covers the sync delay on top of the clear count
  task automatic clear_dim(input int n);
    drive(1'b1, 1'b0, n + 10);
  endtask : clear_dim
  task automatic clear_en(input int n);
    drive(1'b0, dimming_in, n + 10);
  endtask : clear_en
endmodule : host_model

/* tb/tb.sv */
// Testbench for led_fault_supervisor with a host model.
// Assumes short clear and lockout counts set by parameter.
`timescale 1ns/10ps
module tb;
  localparam int unsigned CLR = 16;
  localparam int unsigned LKO = 8;
  logic sys_clk, reset_n, enable_in, dimming_in, lf;
  logic swc = 1'b0;
  logic fn_prev = 1'b1;
  logic bse, ott, dis, fn, sco, lat;
  logic [3:0] snk;
  logic [8:0] rel_cnt = 9'h000;
  logic [8:0] rel_base;
  fault_sup_pkg::fault_flags_t ff;
  fault_sup_pkg::string_flags_t sf;
  int n_errors, checks_done;
  logic [7:0] auto_v [4] = '{8'h80, 8'h40, 8'h20, 8'h01};
  logic [8:0] auto_e [4] = '{9'h07e, 9'h040, 9'h000, 9'h1fe};
  wire [8:0] outs = {bse, ott, dis, snk, fn, lat};
  led_fault_supervisor #(.CLEAR_COUNT(CLR), .LOCKOUT_COUNT(LKO)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .enable_in(enable_in),
    .dimming_in(dimming_in), .low_freq_variant(lf), .switching_clock(swc),
    .fault_flags(ff), .string_flags(sf), .boost_switch_enable(bse),
    .on_time_truncate(ott), .disconnect_on(dis), .sink_enable(snk),
    .fault_n(fn), .switching_clock_output(sco), .latched(lat));
  host_model host (.sys_clk(sys_clk), .enable_in(enable_in), .dimming_in(dimming_in));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) swc <= ~swc;
  // Release counter, sampled mid-cycle to stay clear of the edge
  always @(negedge sys_clk) begin
    if (fn_prev === 1'b0 && fn === 1'b1) rel_cnt = rel_cnt + 9'h001;
    fn_prev = fn;
  end
  task automatic expect_val(input string what, input logic [8:0] exp, input logic [8:0] seen);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : expect_val
  task automatic set_ff(input logic [7:0] v);
    @(posedge sys_clk);
    ff <= fault_sup_pkg::fault_flags_t'(v);
  endtask : set_ff
  task automatic set_sf(input logic [11:0] v);
    @(posedge sys_clk);
    sf <= fault_sup_pkg::string_flags_t'(v);
  endtask : set_sf
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    lf = 1'b0;
    ff = '0;
    sf = '0;
    n_errors = 0;
    checks_done = 0;
    wait_cyc(19);
    expect_val("reset", 9'h002, outs);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    host.drive(1'b1, 1'b1, 6);
    expect_val("start", 9'h17e, outs);
    for (int i = 0; i < 4; i++) begin
      set_ff(auto_v[i]);
      wait_cyc(6);
      expect_val("auto fault", auto_e[i], outs);
      set_ff(8'h00);
      wait_cyc(6);
      expect_val("auto restart", 9'h17e, outs);
    end
    set_sf({4'h1, 4'hf, 4'h2});
    wait_cyc(6);
    expect_val("short off", 9'h17a, outs);
    set_sf({4'h0, 4'hf, 4'h2});
    wait_cyc(6);
    expect_val("short drop", 9'h17e, outs);
    set_sf({4'h1, 4'hf, 4'h2});
    wait_cyc(6);
    set_sf({4'h1, 4'hf, 4'h0});
    wait_cyc(6);
    expect_val("short held", 9'h17a, outs);
    host.drive(1'b1, 1'b0, 3);
    host.drive(1'b1, 1'b1, 6);
    expect_val("short dim rise", 9'h17e, outs);
    for (int i = 0; i < 3; i++) begin
      set_ff(8'h08 >> i);
      wait_cyc(6);
      expect_val("latched", 9'h001, outs);
      set_ff(8'h00);
      host.clear_en(CLR);
      expect_val("enable clear", 9'h002, outs);
      host.drive(1'b1, 1'b0, 3);
      host.drive(1'b1, 1'b1, 6);
      expect_val("restart", 9'h17e, outs);
    end
    set_ff(8'h08);
    wait_cyc(6);
    rel_base = rel_cnt;
    host.clear_dim(CLR);
    expect_val("relatch", 9'h001, outs);
    expect_val("release seen", 9'h001, rel_cnt - rel_base);
    set_ff(8'h00);
    host.drive(1'b1, 1'b1, 6);
    expect_val("no start", 9'h001, outs);
    host.drive(1'b1, 1'b0, CLR - 4);
    host.drive(1'b1, 1'b1, 3);
    host.drive(1'b1, 1'b0, CLR - 4);
    expect_val("count restart", 9'h001, outs);
    host.clear_dim(CLR);
    expect_val("dim clear", 9'h002, outs);
    expect_val("clock out", {8'h00, ~swc}, {8'h00, sco});
    host.drive(1'b1, 1'b1, 6);
    expect_val("dim restart", 9'h17e, outs);
    set_ff(8'h08);
    wait_cyc(6);
    set_ff(8'h10);
    wait_cyc(LKO - 4);
    set_ff(8'h00);
    wait_cyc(6);
    expect_val("glitch", 9'h001, outs);
    set_ff(8'h10);
    wait_cyc(LKO + 10);
    expect_val("lockout", 9'h002, outs);
    set_ff(8'h00);
    wait_cyc(6);
    expect_val("after lockout", 9'h17e, outs);
    // Slow variant: the short count must not clear, the long one must
    @(posedge sys_clk);
    lf <= 1'b1;
    set_ff(8'h08);
    wait_cyc(6);
    set_ff(8'h00);
    host.clear_dim(CLR);
    expect_val("slow still latched", 9'h001, outs);
    host.clear_dim(fault_sup_pkg::CLEAR_CYCLES_LF);
    expect_val("slow clear", 9'h002, outs);
    finish_test();
  end
  // Whole run is about nine thousand cycles, mostly the slow-variant clear
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule : tb
bind led_fault_supervisor fault_sup_asserts #(
  .CLEAR_COUNT(CLEAR_COUNT),
  .LOCKOUT_COUNT(LOCKOUT_COUNT)
) chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .enable_in(enable_in),
  .dimming_in(dimming_in), .switching_clock(switching_clock),
  .fault_flags(fault_flags), .boost_switch_enable(boost_switch_enable),
  .on_time_truncate(on_time_truncate), .disconnect_on(disconnect_on),
  .sink_enable(sink_enable), .fault_n(fault_n),
  .switching_clock_output(switching_clock_output), .latched(latched)
);
